// ==== hdl/identity_pkg.sv ====
package identity_pkg;
  // Bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [15:0] PART_ID_HIGH_OFS = 16'h001a;
  localparam logic [15:0] PART_ID_LOW_OFS = 16'h001b;
  localparam logic [15:0] MEMORY_SIZE_0_OFS = 16'h001c;
  localparam logic [15:0] MEMORY_SIZE_1_OFS = 16'h001d;
  // Reserved and unimplemented range bounds
  localparam logic [15:0] RESERVED_LO = 16'h0280;
  localparam logic [15:0] RESERVED_HI = 16'h03ff;
  // Identification field positions
  localparam int FAMILY_MAJOR_POS = 12;
  localparam int FAMILY_MINOR_POS = 8;
  localparam int MASK_MAJOR_POS = 4;
  localparam int MASK_MINOR_POS = 0;
  // Identification field values, arbitrary neutral values
  localparam logic [3:0] FAMILY_MAJOR_VAL = 4'h1;
  localparam logic [3:0] FAMILY_MINOR_VAL = 4'h2;
  localparam logic [3:0] MASK_MAJOR_VAL = 4'h3;
  localparam logic [3:0] MASK_MINOR_VAL = 4'h4;
  // Memory size constants
  localparam logic [7:0] MEMORY_SIZE_0_VAL = 8'h07;
  localparam logic [7:0] MEMORY_SIZE_1_VAL = 8'h81;
  // Read data after reset
  localparam logic [7:0] READ_DATA_RST = 8'h00;
  // Register selection
  typedef enum logic [4:0]
  {
    SEL_NONE = 5'h01,
    SEL_ID_HIGH = 5'h02,
    SEL_ID_LOW = 5'h04,
    SEL_SIZE_0 = 5'h08,
    SEL_SIZE_1 = 5'h10
  } reg_sel_t;
endpackage : identity_pkg

// ==== hdl/id_decode_if.sv ====
`timescale 1ns/10ps
interface id_decode_if;
  import identity_pkg::*;
  logic [ADDR_W-1:0] addr;
  reg_sel_t sel;
  logic in_reserved;
  modport decoder (input addr, output sel, output in_reserved);
  modport user (output addr, input sel, input in_reserved);
endinterface : id_decode_if

// ==== hdl/id_addr_decode.sv ====
`timescale 1ns/10ps
module id_addr_decode
(
  // Address in, selection out
  id_decode_if.decoder dec
);
  import identity_pkg::*;

  // Range check for the zero-read window
  assign dec.in_reserved = (dec.addr >= RESERVED_LO) && (dec.addr <= RESERVED_HI);

  // One-hot select of the four fixed registers
  assign dec.sel = (dec.addr == PART_ID_HIGH_OFS) ? SEL_ID_HIGH :
                   (dec.addr == PART_ID_LOW_OFS) ? SEL_ID_LOW :
                   (dec.addr == MEMORY_SIZE_0_OFS) ? SEL_SIZE_0 :
                   (dec.addr == MEMORY_SIZE_1_OFS) ? SEL_SIZE_1 : SEL_NONE;
endmodule : id_addr_decode

// ==== hdl/device_identity_regs.sv ====
// Our own choice: the strobed register port.
`timescale 1ns/10ps
module device_identity_regs
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic SRST,
  // Register port
  input wire logic [identity_pkg::ADDR_W-1:0] ADDR,
  input wire logic [identity_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [identity_pkg::DATA_W-1:0] RDATA
);
  import identity_pkg::*;

  logic [15:0] part_id;
  logic [DATA_W-1:0] next_rdata;
  logic hit_id_high;
  logic hit_id_low;
  logic hit_size_0;
  logic hit_size_1;
  logic rd_reserved;
  id_decode_if dif ();

  // Place a 4-bit field at its bit position in the 16-bit id
  function automatic logic [15:0] place_field(input logic [3:0] val, input int pos);
    place_field = 16'(val) << pos;
  endfunction : place_field

  // True when an address lies in the zero-read window
  function automatic logic in_window(input logic [ADDR_W-1:0] a);
    in_window = (a >= RESERVED_LO) && (a <= RESERVED_HI);
  endfunction : in_window

  // Assemble the 16-bit identification from its fields
  assign part_id = place_field(FAMILY_MAJOR_VAL, FAMILY_MAJOR_POS)
                 | place_field(FAMILY_MINOR_VAL, FAMILY_MINOR_POS)
                 | place_field(MASK_MAJOR_VAL, MASK_MAJOR_POS)
                 | place_field(MASK_MINOR_VAL, MASK_MINOR_POS);

  // Address decode
  assign dif.addr = ADDR;
  id_addr_decode u_dec
  (
    .dec(dif.decoder)
  );

  // Named hits of the decoder, qualified by the read strobe
  assign hit_id_high = RD && (dif.sel == SEL_ID_HIGH);
  assign hit_id_low = RD && (dif.sel == SEL_ID_LOW);
  assign hit_size_0 = RD && (dif.sel == SEL_SIZE_0);
  assign hit_size_1 = RD && (dif.sel == SEL_SIZE_1);
  assign rd_reserved = RD && dif.in_reserved;

  // Read mux; constants only, so writes have nothing to store
  assign next_rdata = rd_reserved ? READ_DATA_RST : // window reads zero
                      hit_id_high ? part_id[15:8] :
                      hit_id_low ? part_id[7:0] :
                      hit_size_0 ? MEMORY_SIZE_0_VAL :
                      hit_size_1 ? MEMORY_SIZE_1_VAL :
                      READ_DATA_RST; // Unmapped or no read gives zero

  // Read data register, valid the cycle after the strobe
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      RDATA <= READ_DATA_RST;
    else
      RDATA <= next_rdata; // WR and WDATA never reach state
  end

  // Checks
  sequence s_read_id_high;
    RD && ADDR == PART_ID_HIGH_OFS;
  endsequence

  sequence s_read_id_low;
    RD && ADDR == PART_ID_LOW_OFS;
  endsequence

  sequence s_read_size_0;
    RD && ADDR == MEMORY_SIZE_0_OFS;
  endsequence

  sequence s_read_size_1;
    RD && ADDR == MEMORY_SIZE_1_OFS;
  endsequence

  // Read or write anywhere in the zero-read window
  sequence s_read_window;
    RD && in_window(ADDR);
  endsequence

  sequence s_write_window;
    WR && in_window(ADDR);
  endsequence

  sequence s_write_only;
    WR && !RD;
  endsequence

  property p_reserved_zero;
    @(posedge SYS_CLK) disable iff (SRST)
    s_read_window |=> RDATA == READ_DATA_RST;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved read not zero");

  property p_id_high;
    @(posedge SYS_CLK) disable iff (SRST)
    s_read_id_high |=> RDATA == {FAMILY_MAJOR_VAL, FAMILY_MINOR_VAL};
  endproperty
  a_id_high: assert property (p_id_high) else $error("id high byte wrong");

  property p_id_low;
    @(posedge SYS_CLK) disable iff (SRST)
    s_read_id_low |=> RDATA == {MASK_MAJOR_VAL, MASK_MINOR_VAL};
  endproperty
  a_id_low: assert property (p_id_low) else $error("id low byte wrong");

  property p_id_stable;
    @(posedge SYS_CLK) disable iff (SRST)
    s_read_id_high ##1 (WR && ADDR == PART_ID_HIGH_OFS) ##1 s_read_id_high |=> RDATA == $past(RDATA, 2);
  endproperty
  a_id_stable: assert property (p_id_stable) else $error("id changed by write");

  property p_family;
    @(posedge SYS_CLK) disable iff (SRST)
    s_read_id_high |=> RDATA[7:4] == FAMILY_MAJOR_VAL && RDATA[3:0] == FAMILY_MINOR_VAL;
  endproperty
  a_family: assert property (p_family) else $error("family fields wrong");

  property p_size0;
    @(posedge SYS_CLK) disable iff (SRST)
    s_read_size_0 |=> RDATA == MEMORY_SIZE_0_VAL;
  endproperty
  a_size0: assert property (p_size0) else $error("size 0 wrong");

  property p_size1;
    @(posedge SYS_CLK) disable iff (SRST)
    s_read_size_1 |=> RDATA == MEMORY_SIZE_1_VAL;
  endproperty
  a_size1: assert property (p_size1) else $error("size 1 wrong");

  property p_write_no_data;
    @(posedge SYS_CLK) disable iff (SRST)
    s_write_only |=> RDATA == READ_DATA_RST;
  endproperty
  a_write_no_data: assert property (p_write_no_data) else $error("write produced read data");

  // Output held at zero through reset
  property p_reset_zero;
    @(posedge SYS_CLK)
    SRST |=> RDATA == READ_DATA_RST;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("read data not zero after reset");

  // No read strobe, no read data
  property p_idle_zero;
    @(posedge SYS_CLK) disable iff (SRST)
    !RD |=> RDATA == READ_DATA_RST;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data without a read");

  // Both window bounds read zero
  property p_window_low_end;
    @(posedge SYS_CLK) disable iff (SRST)
    RD && ADDR == RESERVED_LO |=> RDATA == READ_DATA_RST;
  endproperty
  a_window_low_end: assert property (p_window_low_end) else $error("window low bound not zero");

  property p_window_high_end;
    @(posedge SYS_CLK) disable iff (SRST)
    RD && ADDR == RESERVED_HI |=> RDATA == READ_DATA_RST;
  endproperty
  a_window_high_end: assert property (p_window_high_end) else $error("window high bound not zero");

  // High byte then low byte on back-to-back reads
  property p_id_pair;
    @(posedge SYS_CLK) disable iff (SRST)
    s_read_id_high ##1 s_read_id_low |->
      RDATA == {FAMILY_MAJOR_VAL, FAMILY_MINOR_VAL} ##1 RDATA == {MASK_MAJOR_VAL, MASK_MINOR_VAL};
  endproperty
  a_id_pair: assert property (p_id_pair) else $error("id byte order wrong");

  // Mask revision fields in the low byte
  property p_mask_fields;
    @(posedge SYS_CLK) disable iff (SRST)
    s_read_id_low |=> RDATA[7:4] == MASK_MAJOR_VAL && RDATA[3:0] == MASK_MINOR_VAL;
  endproperty
  a_mask_fields: assert property (p_mask_fields) else $error("mask fields wrong");

  // Low id byte survives a write between two reads
  property p_id_low_stable;
    @(posedge SYS_CLK) disable iff (SRST)
    s_read_id_low ##1 (WR && ADDR == PART_ID_LOW_OFS) ##1 s_read_id_low |=> RDATA == $past(RDATA, 2);
  endproperty
  a_id_low_stable: assert property (p_id_low_stable) else $error("id low changed by write");

  // Size registers read in address order
  property p_size_pair;
    @(posedge SYS_CLK) disable iff (SRST)
    s_read_size_0 ##1 s_read_size_1 |-> RDATA == MEMORY_SIZE_0_VAL ##1 RDATA == MEMORY_SIZE_1_VAL;
  endproperty
  a_size_pair: assert property (p_size_pair) else $error("size pair wrong");

  // Size registers survive a write between two reads
  property p_size0_stable;
    @(posedge SYS_CLK) disable iff (SRST)
    s_read_size_0 ##1 (WR && ADDR == MEMORY_SIZE_0_OFS) ##1 s_read_size_0 |=> RDATA == $past(RDATA, 2);
  endproperty
  a_size0_stable: assert property (p_size0_stable) else $error("size 0 changed by write");

  property p_size1_stable;
    @(posedge SYS_CLK) disable iff (SRST)
    s_read_size_1 ##1 (WR && ADDR == MEMORY_SIZE_1_OFS) ##1 s_read_size_1 |=> RDATA == $past(RDATA, 2);
  endproperty
  a_size1_stable: assert property (p_size1_stable) else $error("size 1 changed by write");

  // Window still reads zero after a write into it
  property p_window_write;
    @(posedge SYS_CLK) disable iff (SRST)
    s_read_window ##1 s_write_window ##1 s_read_window |=> RDATA == READ_DATA_RST;
  endproperty
  a_window_write: assert property (p_window_write) else $error("window write left data");
endmodule : device_identity_regs

// ==== sim/core_model.sv ====
`timescale 1ns/10ps
// Core side of the register port
module core_model
(
  // Clock
  input wire logic SYS_CLK,
  // Register port
  output logic [identity_pkg::ADDR_W-1:0] ADDR,
  output logic [identity_pkg::DATA_W-1:0] WDATA,
  output logic WR,
  output logic RD
);
  import identity_pkg::*;
  initial {ADDR, WDATA, WR, RD} = '0;
  // One strobe cycle; next call may follow at once
  task automatic cyc(input logic w, input logic [15:0] a, input logic [7:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= w;
    RD <= !w;
    @(posedge SYS_CLK);
  endtask : cyc
  // Drop both strobes
  task automatic idle;
    WR <= 1'b0;
    RD <= 1'b0;
    @(posedge SYS_CLK);
  endtask : idle
endmodule : core_model

// ==== sim/test_device_identity_regs.sv ====
`timescale 1ns/10ps
module test_device_identity_regs;
  import identity_pkg::*;
  logic SYS_CLK = 1'b0;
  logic SRST = 1'b1;
  logic [15:0] ADDR;
  logic [7:0] WDATA;
  logic [7:0] RDATA;
  logic WR;
  logic RD;
  logic [7:0] notes[$];
  logic rd_seen = 1'b0;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 32'h377b33ef;
  initial forever #4 SYS_CLK = !SYS_CLK;
  device_identity_regs uut (.SYS_CLK(SYS_CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA));
  core_model core (.SYS_CLK(SYS_CLK), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // Read with its expected value noted
  task automatic rd(input logic [15:0] a);
    case (a)
      PART_ID_HIGH_OFS: notes.push_back({FAMILY_MAJOR_VAL, FAMILY_MINOR_VAL});
      PART_ID_LOW_OFS: notes.push_back({MASK_MAJOR_VAL, MASK_MINOR_VAL});
      MEMORY_SIZE_0_OFS: notes.push_back(MEMORY_SIZE_0_VAL);
      MEMORY_SIZE_1_OFS: notes.push_back(MEMORY_SIZE_1_VAL);
      default: notes.push_back(READ_DATA_RST);
    endcase
    core.cyc(1'b0, a, 8'h00);
  endtask : rd
  // Output watcher and hang guard
  always @(posedge SYS_CLK)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      err_total++;
      conclude();
    end
    else
    begin
      if (rd_seen)
        check(RDATA, notes.pop_front());
      else if (cycles > 1)
        check(RDATA, READ_DATA_RST);
      rd_seen = RD;
    end
  end
  // Main sequence
  initial
  begin
    logic [15:0] a;
    repeat (12) @(posedge SYS_CLK);
    SRST <= 1'b0;
    @(posedge SYS_CLK);
    for (int i = 0; i < 4; i++)
      rd(16'(PART_ID_HIGH_OFS + i));
    core.idle();
    $display("register reads done");
    for (int i = 0; i < 4; i++)
    begin
      rd(16'(PART_ID_HIGH_OFS + i));
      core.cyc(1'b1, 16'(PART_ID_HIGH_OFS + i), 8'($random(seed)));
      rd(16'(PART_ID_HIGH_OFS + i));
    end
    core.idle();
    $display("write attempts done");
    rd(RESERVED_LO);
    rd(RESERVED_HI);
    rd(16'(RESERVED_LO - 1));
    rd(16'(RESERVED_HI + 1));
    for (int i = 0; i < 20; i++)
    begin
      a = 16'(RESERVED_LO + ($random(seed) & 16'h017f));
      rd(a);
      core.cyc(1'b1, a, 8'($random(seed)));
      rd(a);
      rd(16'(PART_ID_HIGH_OFS + (i % 4)));
    end
    core.idle();
    $display("reserved range done");
    repeat (2) @(posedge SYS_CLK);
    conclude();
  end
endmodule : test_device_identity_regs
